// *** src/mods_ctrl.sv ***
// Overload-relay and direct-on-line starter control for a motor controller.
// Assumes fieldbus images are updated synchronously to core_clk_i and a
// separate protection core reports fault and warning levels.
//
// How it works
// R1: Overload mode passes relay two, switched DC and inputs straight through.
// R2: A configured fault output ignores its bus command bit.
// R3: After reset in overload mode main relay closes, auxiliary opens.
// R4: Overload fault opens main, closes auxiliary, drives configured fault output.
// R5: Fault is reported in the status byte summary fault bit.
// R6: Red lamp is lit while fault is latched.
// R7: Panel fault indicator flashes during fault.
// R8: Overload mode offers no checkback, start/stop or dip handling.
// R9: Overload status byte warning, fault and overload bits; input image bits.
// R10: Master places reset, emergency, relay two and DC commands in bytes.
// R11: Direct mode switches contactor with main relay output only.
// R12: Direct mode optionally supervises contactor checkback on input zero.
// R13: Direct mode optionally starts from input four, stops from five.
// R14: Direct mode optionally uses DC output or relay two as fault output.
// R15: Direct status byte carries warn, fault, local, overload, run, off.
// R16: Master places auto, run forward and off in command byte 0.
// R17: Direct relay closes on run, opens on off or fault; status mirrors.
// R18: Fault reset clears latch only after cause disappears.
`timescale 1ns/1ps
`include "mods_map.svh"

module mods_ctrl
    import mods_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYC = `MODS_FLASH_HALF_CYC,
    parameter int unsigned CHECKBACK_CYC  = 40_000
) (
    // Clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // Configuration
    input  wire logic       func_direct_i,
    input  wire logic [1:0] fault_out_sel_i,
    input  wire logic       checkback_en_i,
    input  wire logic       local_en_i,
    // Protection core
    input  wire logic       fault_cause_i,
    input  wire logic       warn_i,
    input  wire logic       overload_warn_i,
    // Fieldbus command images
    input  wire logic [7:0] command_byte_i,
    input  wire logic [7:0] output_command_i,
    // Digital input pins
    input  wire logic [5:0] digital_input_i,
    // Fieldbus monitoring images
    output logic      [7:0] status_byte_o,
    output logic      [7:0] input_image_o,
    // Relay and output pins
    output logic            main_relay_output_o,
    output logic            auxiliary_relay_output_o,
    output logic            relay_output_two_o,
    output logic            switched_dc_output_o,
    // Indicators
    output logic            red_led_o,
    output logic            panel_fault_o
);

    // ======================================================================
    // Parameter checks
    localparam int FW = $clog2(FLASH_HALF_CYC + 1);
    localparam int CW = $clog2(CHECKBACK_CYC + 1);

    initial begin
        if (FLASH_HALF_CYC < 1 || CHECKBACK_CYC < 1) begin
            $error("mods_ctrl: counts must be at least one");
        end
    end

    // ======================================================================
    // State
    typedef struct packed {
        mods_run_t   run;
        logic        fault;
        logic        cb_fault;
        logic [CW-1:0] cb_cnt;
        logic [FW-1:0] fl_cnt;
        logic        fl_phase;
        logic [7:0]  status;
        logic [7:0]  inputs;
        logic        main_rly;
        logic        aux_rly;
        logic        rly_two;
        logic        sw_dc;
        logic        red;
        logic        panel;
    } mods_state_t;

    mods_state_t cur;
    mods_state_t next_st;

    mods_func_t func;
    mods_fout_t fsel;
    assign func = mods_func_t'(func_direct_i);
    assign fsel = mods_fout_t'(fault_out_sel_i);

    // Fault-output value for a terminal when it is so configured
    function automatic logic pick_out(input mods_fout_t sel, input mods_fout_t me,
                                      input logic flt, input logic bus);
        pick_out = (sel == me) ? flt : bus;
    endfunction

    // ======================================================================
    // Next-state logic
    always_comb begin
        logic cause;
        logic do_reset;
        logic start_req;
        logic stop_req;
        logic local_ctl;
        cause     = 1'b0;
        do_reset  = 1'b0;
        start_req = 1'b0;
        stop_req  = 1'b0;
        local_ctl = 1'b0;
        next_st   = cur;

        // R8: checkback and start/stop only exist in direct mode
        local_ctl = (func == MODS_FN_DIRECT) && local_en_i &&
                    !command_byte_i[`MODS_CMD_AUTO];

        // R12: checkback supervision of main contactor
        if (func == MODS_FN_DIRECT && checkback_en_i &&
            (digital_input_i[0] != cur.main_rly)) begin
            if (cur.cb_cnt >= CW'(CHECKBACK_CYC)) begin
                next_st.cb_fault = 1'b1;
            end else begin
                next_st.cb_cnt = cur.cb_cnt + CW'(1);
            end
        end else begin
            next_st.cb_cnt = '0;
            if (func != MODS_FN_DIRECT || !checkback_en_i) begin
                next_st.cb_fault = 1'b0;
            end
        end

        cause    = fault_cause_i || cur.cb_fault;
        do_reset = command_byte_i[`MODS_CMD_FAULT_RESET];

        // R18: latched fault, set wins over reset
        if (cause) begin
            next_st.fault = 1'b1;
        end else if (do_reset) begin
            next_st.fault = 1'b0;
            next_st.cb_fault = 1'b0;
        end

        // R13: local inputs four/five, R16: bus commands in auto mode
        if (local_ctl) begin
            start_req = digital_input_i[4];
            stop_req  = digital_input_i[5];
        end else begin
            start_req = command_byte_i[`MODS_CMD_RUN_FWD];
            stop_req  = command_byte_i[`MODS_CMD_OFF];
        end

        // R17: run state machine; stop has priority over start
        unique case (cur.run)
            MODS_RS_OFF: begin
                if (start_req && !stop_req && !next_st.fault) begin
                    next_st.run = MODS_RS_RUN;
                end
            end
            MODS_RS_RUN: begin
                if (cause || next_st.fault) begin
                    next_st.run = MODS_RS_TRIP;
                end else if (stop_req) begin
                    next_st.run = MODS_RS_OFF;
                end
            end
            MODS_RS_TRIP: begin
                if (!next_st.fault) begin
                    next_st.run = MODS_RS_OFF;
                end
            end
            default: next_st.run = MODS_RS_OFF;
        endcase
        if (func != MODS_FN_DIRECT) begin
            next_st.run = MODS_RS_OFF;
        end

        // R7: flash timer runs only while fault is latched
        if (next_st.fault) begin
            if (cur.fl_cnt >= FW'(FLASH_HALF_CYC - 1)) begin
                next_st.fl_cnt   = '0;
                next_st.fl_phase = ~cur.fl_phase;
            end else begin
                next_st.fl_cnt = cur.fl_cnt + FW'(1);
            end
        end else begin
            next_st.fl_cnt   = '0;
            next_st.fl_phase = 1'b1;
        end
        // R7: panel indicator flashes
        next_st.panel = next_st.fault && next_st.fl_phase;
        // R6: red lamp steady while faulted
        next_st.red   = next_st.fault;

        if (func == MODS_FN_OVERLOAD) begin
            // R3: main closed, auxiliary open; R4: swapped on fault
            next_st.main_rly = !next_st.fault;
            next_st.aux_rly  = next_st.fault;
        end else begin
            // R11: only main relay switches the contactor
            next_st.main_rly = (next_st.run == MODS_RS_RUN);
            next_st.aux_rly  = 1'b0;
        end

        // R1: bus straight through; R2: R4: R14: fault output overrides
        next_st.rly_two = pick_out(fsel, MODS_FO_RELAY_TWO, next_st.fault,
                                   output_command_i[`MODS_OC_RELAY_TWO]);
        next_st.sw_dc   = pick_out(fsel, MODS_FO_SW_DC, next_st.fault,
                                   output_command_i[`MODS_OC_SWITCHED_DC]);

        // R9: R1: raw inputs in bits 7..2
        next_st.inputs = {digital_input_i, 2'b00};

        // R5: R9: R15: status byte
        next_st.status = 8'h00;
        next_st.status[`MODS_ST_SUM_WARN]  = warn_i || overload_warn_i;
        next_st.status[`MODS_ST_SUM_FAULT] = next_st.fault;
        next_st.status[`MODS_ST_OVL_WARN]  = overload_warn_i;
        if (func == MODS_FN_DIRECT) begin
            next_st.status[`MODS_ST_LOCAL]   = local_ctl;
            next_st.status[`MODS_ST_RUN_FWD] = (next_st.run == MODS_RS_RUN);
            next_st.status[`MODS_ST_OFF]     = (next_st.run != MODS_RS_RUN);
        end
    end

    // ======================================================================
    // State register; reset leaves main relay closed for overload mode
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cur          <= '0;
            // R3: main relay closed straight after power-up in overload mode;
            // R17: a direct starter must not pull in its contactor unasked
            cur.main_rly <= !func_direct_i;
            cur.fl_phase <= 1'b1;
            cur.status   <= 8'h00;
        end else begin
            cur <= next_st;
        end
    end

    // ======================================================================
    // Outputs straight from flip-flops
    assign status_byte_o            = cur.status;
    assign input_image_o            = cur.inputs;
    assign main_relay_output_o      = cur.main_rly;
    assign auxiliary_relay_output_o = cur.aux_rly;
    assign relay_output_two_o       = cur.rly_two;
    assign switched_dc_output_o     = cur.sw_dc;
    assign red_led_o                = cur.red;
    assign panel_fault_o            = cur.panel;

endmodule

// *** src/mods_map.svh ***
// Offsets, bit positions and timing counts of the motor overload / direct starter block.
// Assumes inclusion by its bare name from the package and the design module.
`ifndef MODS_MAP_SVH
`define MODS_MAP_SVH

// ==========================================================================
// Image byte offsets
`define MODS_STATUS_BYTE_OFS   1'h0
`define MODS_INPUT_BYTE_OFS    1'h1
`define MODS_CMD_BYTE_OFS      1'h0
`define MODS_OUTCMD_BYTE_OFS   1'h1

// ==========================================================================
// Status byte 0 bit positions
`define MODS_ST_SUM_WARN       7
`define MODS_ST_SUM_FAULT      6
`define MODS_ST_LOCAL          5
`define MODS_ST_OVL_WARN       3
`define MODS_ST_RUN_FWD        2
`define MODS_ST_OFF            1

// Input image byte 1: inputs five..zero in bits 7..2
`define MODS_IN_LSB            2

// ==========================================================================
// Command byte 0 bit positions
`define MODS_CMD_FAULT_RESET   6
`define MODS_CMD_AUTO          5
`define MODS_CMD_PREP_EMERG    4
`define MODS_CMD_RUN_FWD       2
`define MODS_CMD_OFF           1

// Output command byte 1 bit positions
`define MODS_OC_RELAY_TWO      7
`define MODS_OC_SWITCHED_DC    4

// ==========================================================================
// Panel fault indicator flash: half period in ms at 40 MHz
`define MODS_CLK_HZ            40_000_000
`define MODS_FLASH_HALF_MS     250
`define MODS_FLASH_HALF_CYC    ((`MODS_CLK_HZ / 1000) * `MODS_FLASH_HALF_MS)

`endif

// *** src/mods_pkg.sv ***
// Types of the motor overload / direct starter block.
// Assumes mods_map.svh is on the include path.
package mods_pkg;
    `include "mods_map.svh"

    // Control function selected by configuration
    typedef enum logic {
        MODS_FN_OVERLOAD = 1'b0,
        MODS_FN_DIRECT   = 1'b1
    } mods_func_t;

    // Which terminal, if any, carries the fault output
    typedef enum logic [1:0] {
        MODS_FO_NONE      = 2'h0,
        MODS_FO_RELAY_TWO = 2'h1,
        MODS_FO_SW_DC     = 2'h2
    } mods_fout_t;

    // Direct starter run state, Gray along off -> run -> tripped
    typedef enum logic [1:0] {
        MODS_RS_OFF  = 2'b00,
        MODS_RS_RUN  = 2'b01,
        MODS_RS_TRIP = 2'b11
    } mods_run_t;
endpackage

// *** tb/mods_ctrl_monitor.sv ***
// Port checker for mods_ctrl, bound to every instance of it.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
// ==============================================================
// Checker
module mods_ctrl_monitor #(
    parameter int unsigned FLASH_HALF_CYC = 4
) (
    // Clock, reset and inputs
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic       func_direct_i,
    input wire logic [1:0] fault_out_sel_i,
    input wire logic       fault_cause_i,
    input wire logic       warn_i,
    input wire logic       overload_warn_i,
    input wire logic [7:0] command_byte_i,
    input wire logic [7:0] output_command_i,
    input wire logic [5:0] digital_input_i,
    // Outputs
    input wire logic [7:0] status_byte_o,
    input wire logic [7:0] input_image_o,
    input wire logic       main_relay_output_o,
    input wire logic       auxiliary_relay_output_o,
    input wire logic       relay_output_two_o,
    input wire logic       red_led_o,
    input wire logic       panel_fault_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [31:0] same_cnt;
    logic        last_panel;
    // Steady panel run while faulted; a stuck lamp would grow it unbounded
    always_ff @(posedge core_clk_i) begin
        last_panel <= panel_fault_o;
        if (!rst_n_i || !red_led_o || panel_fault_o != last_panel)
            same_cnt <= '0;
        else
            same_cnt <= same_cnt + 1;
    end
    a_ovl_main_trip: assert property (!func_direct_i |-> main_relay_output_o == !red_led_o)
        else $error("main relay disagrees with fault state");
    a_ovl_aux_trip: assert property (!func_direct_i |-> auxiliary_relay_output_o == red_led_o)
        else $error("auxiliary relay disagrees with fault state");
    a_fault_sets: assert property (fault_cause_i |=> red_led_o && status_byte_o[6])
        else $error("fault not latched to lamp and status");
    a_reset_clears: assert property (!func_direct_i && !fault_cause_i && command_byte_i[6]
        |=> !red_led_o)
        else $error("fault reset did not clear");
    a_latch_holds: assert property (red_led_o && !command_byte_i[6] |=> red_led_o)
        else $error("fault cleared without reset");
    a_warn_bits: assert property (1'b1 |=> status_byte_o[7] == $past(warn_i | overload_warn_i)
        && status_byte_o[3] == $past(overload_warn_i))
        else $error("warning bits wrong");
    a_input_pass: assert property (1'b1 |=> input_image_o == {$past(digital_input_i), 2'h0})
        else $error("input image wrong");
    a_relay2_fault: assert property (fault_out_sel_i == 2'h1 |=> relay_output_two_o == red_led_o)
        else $error("relay two not driven by fault");
    a_relay2_bus: assert property (fault_out_sel_i != 2'h1
        |=> relay_output_two_o == $past(output_command_i[7]))
        else $error("relay two not following bus");
    a_off_wins: assert property (func_direct_i && command_byte_i[1] |=> !main_relay_output_o)
        else $error("off command did not open relay");
    a_run_status: assert property (func_direct_i && $past(rst_n_i)
        |-> status_byte_o[2] == main_relay_output_o)
        else $error("run status differs from relay");
    a_panel_flash: assert property (red_led_o |-> same_cnt <= FLASH_HALF_CYC)
        else $error("panel indicator not flashing");
    c_trip: cover property (fault_cause_i ##1 red_led_o);
    c_run: cover property (func_direct_i && main_relay_output_o);
    c_clear: cover property (red_led_o && command_byte_i[6] && !fault_cause_i);
endmodule
bind mods_ctrl mods_ctrl_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) mods_ctrl_monitor_i (.*);

// *** tb/mods_master_model.sv ***
// Fieldbus master model: packs requested commands into the command images.
// Assumes the bench changes requests off the sampling edge.
`timescale 1ns/1ps
// ==============================================================
// Master
module mods_master_model (
    // Requested commands
    input  wire logic       fault_reset_i,
    input  wire logic       auto_i,
    input  wire logic       prep_emerg_i,
    input  wire logic       run_fwd_i,
    input  wire logic       off_i,
    input  wire logic       relay_two_i,
    input  wire logic       sw_dc_i,
    // Command images
    output logic      [7:0] command_byte_o,
    output logic      [7:0] output_command_o
);
    assign command_byte_o = {1'h0, fault_reset_i, auto_i, prep_emerg_i, 1'h0, run_fwd_i, off_i, 1'h0};
    assign output_command_o = {relay_two_i, 2'h0, sw_dc_i, 4'h0};
endmodule

// *** tb/mods_ctrl_bench.sv ***
// Self-checking bench for mods_ctrl driven through a fieldbus master model.
// Assumes short flash and checkback counts given by parameter.
`timescale 1ns/1ps
// ==============================================================
// Bench
module mods_ctrl_bench;
    import mods_pkg::*;
    localparam int unsigned FH = 4;
    localparam int unsigned CB = 8;
    logic       core_clk_i = 1'h0, rst_n_i = 1'h0, func_direct_i = 1'h0;
    logic       checkback_en_i = 1'h0, local_en_i = 1'h0, fault_cause_i = 1'h0;
    logic       warn_i = 1'h0, overload_warn_i = 1'h0;
    logic [1:0] fault_out_sel_i = 2'h0;
    logic [5:0] digital_input_i = 6'h00;
    logic       f_rst = 1'h0, f_auto = 1'h0, f_em = 1'h0, f_run = 1'h0;
    logic       f_off = 1'h0, f_r2 = 1'h0, f_dc = 1'h0;
    logic [7:0] command_byte_i, output_command_i, status_byte_o, input_image_o;
    logic       main_relay_output_o, auxiliary_relay_output_o, relay_output_two_o;
    logic       switched_dc_output_o, red_led_o, panel_fault_o;
    int         err_total = 0, tests_run = 0, seed = 58460;
    mods_master_model mods_master_model_i (.fault_reset_i(f_rst), .auto_i(f_auto),
        .prep_emerg_i(f_em), .run_fwd_i(f_run), .off_i(f_off), .relay_two_i(f_r2),
        .sw_dc_i(f_dc), .command_byte_o(command_byte_i), .output_command_o(output_command_i));
    mods_ctrl #(.FLASH_HALF_CYC(FH), .CHECKBACK_CYC(CB)) mods_ctrl_i (.*);
    // 40 MHz clock
    initial begin
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Settle past the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic do_reset(input logic dir);
        @(negedge core_clk_i);
        rst_n_i = 1'h0;
        func_direct_i = dir;
        {f_rst, f_auto, f_em, f_run, f_off, f_r2, f_dc} = 7'h00;
        {fault_cause_i, checkback_en_i, local_en_i} = 3'h0;
        repeat (12) @(negedge core_clk_i);
        rst_n_i = 1'h1;
    endtask
    function automatic logic fo_exp(input logic [1:0] sel, input logic [1:0] code,
                                    input logic flt, input logic bus);
        return (sel == code) ? flt : bus;
    endfunction
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog: the whole run needs about a hundred cycles
    initial begin
        #(25 * 3000);
        err_total++;
        wrap_up();
    end
    initial begin
        int n;
        do_reset(1'h0);
        tick(1);
        chk("main", main_relay_output_o, 1'h1);
        chk("aux", auxiliary_relay_output_o, 1'h0);
        // Random images; starter commands must have no effect here
        repeat (20) begin
            @(negedge core_clk_i);
            {digital_input_i, f_r2, f_dc, warn_i, overload_warn_i, f_run, f_off, f_auto, f_em}
                = 14'($random(seed));
            tick(1);
            chk("image", input_image_o, {digital_input_i, 2'h0});
            chk("relay2", relay_output_two_o, f_r2);
            chk("swdc", switched_dc_output_o, f_dc);
            chk("status", status_byte_o,
                {warn_i | overload_warn_i, 3'h0, overload_warn_i, 3'h0});
            chk("main", main_relay_output_o, 1'h1);
        end
        $display("test passthrough done");
        for (int s = 0; s < 3; s++) begin
            @(negedge core_clk_i);
            {f_run, f_off, f_auto, f_r2, f_dc} = 5'h00;
            fault_out_sel_i = 2'(s);
            fault_cause_i = 1'h1;
            tick(1);
            chk("main", main_relay_output_o, 1'h0);
            chk("aux", auxiliary_relay_output_o, 1'h1);
            chk("fault", status_byte_o[6], 1'h1);
            chk("relay2", relay_output_two_o, fo_exp(fault_out_sel_i, 2'h1, 1'h1, f_r2));
            chk("swdc", switched_dc_output_o, fo_exp(fault_out_sel_i, 2'h2, 1'h1, f_dc));
            n = 0;
            repeat (2 * FH) begin
                n += int'(panel_fault_o);
                chk("red", red_led_o, 1'h1);
                tick(1);
            end
            chk("flash", 8'(n), 8'(FH));
            @(negedge core_clk_i);
            f_rst = 1'h1;
            tick(1);
            chk("held", red_led_o, 1'h1);
            @(negedge core_clk_i);
            fault_cause_i = 1'h0;
            tick(1);
            chk("clear", {red_led_o, main_relay_output_o}, 2'h1);
            @(negedge core_clk_i);
            f_rst = 1'h0;
        end
        $display("test overload fault done");
        do_reset(1'h1);
        chk("dreset", main_relay_output_o, 1'h0);
        fault_out_sel_i = 2'h2;
        {f_auto, f_run} = 2'h3;
        tick(2);
        chk("run", {main_relay_output_o, status_byte_o[2:1]}, 3'h6);
        @(negedge core_clk_i);
        f_off = 1'h1;
        tick(1);
        chk("off", {main_relay_output_o, status_byte_o[2:1]}, 3'h1);
        @(negedge core_clk_i);
        {f_off, f_run, f_auto, local_en_i, digital_input_i} = {4'h1, 6'h10};
        tick(1);
        chk("local", {status_byte_o[5], main_relay_output_o}, 2'h3);
        @(negedge core_clk_i);
        digital_input_i = 6'h20;
        tick(1);
        chk("lstop", main_relay_output_o, 1'h0);
        @(negedge core_clk_i);
        {f_auto, f_run, local_en_i, digital_input_i} = {3'h6, 6'h00};
        tick(1);
        @(negedge core_clk_i);
        {f_run, fault_cause_i} = 2'h1;
        tick(1);
        chk("trip", {main_relay_output_o, switched_dc_output_o}, 2'h1);
        @(negedge core_clk_i);
        {fault_cause_i, f_rst} = 2'h1;
        tick(1);
        chk("rearm", {red_led_o, main_relay_output_o}, 2'h0);
        @(negedge core_clk_i);
        {f_rst, f_run, checkback_en_i} = 3'h3;
        tick(CB + 4);
        chk("checkback", {red_led_o, main_relay_output_o}, 2'h2);
        $display("test direct starter done");
        wrap_up();
    end
endmodule
